//--- sc_defines.vh
/*
 * register offsets, fields, commands and reset values of the serial channel.
 * assumes a 3-bit word index on the register port and 8-bit data.
 */
`ifndef SC_DEFINES_VH
`define SC_DEFINES_VH
// ****************
// register offsets
// ****************
`define SC_A_DATA 3'h0
`define SC_A_CTRL 3'h1
`define SC_A_MODE 3'h2
`define SC_A_SYNC1 3'h3
`define SC_A_SYNC2 3'h4
`define SC_A_CMD 3'h5
`define SC_A_STAT 3'h6
`define SC_A_ERR 3'h7
// ****************
// control bits
// ****************
`define SC_C_TXEN 0
`define SC_C_RXEN 1
`define SC_C_AUTO 2
`define SC_C_BRK 3
`define SC_C_CRCEN 4
`define SC_C_HUNT 5
`define SC_C_TXIE 6
`define SC_C_ESIE 7
// ****************
// mode fields
// ****************
`define SC_M_SYNC 1:0
`define SC_M_BITS 3:2
`define SC_M_X16 4
`define SC_M_RXIM 7:6
`define SC_SY_ASYNC 2'h0
`define SC_SY_MONO 2'h1
`define SC_SY_BI 2'h2
`define SC_SY_EXT 2'h3
`define SC_RI_FIRST 2'h1
`define SC_RI_EVERY 2'h2
// ****************
// commands and constants
// ****************
`define SC_CMD_RST_ES 3'h2
`define SC_CMD_RST_CRC 3'h3
`define SC_CMD_REARM 3'h4
`define SC_CMD_RST_TXI 3'h5
`define SC_CMD_ERR_RST 3'h6
`define SC_CMD_RST_SENT 3'h7
`define SC_CRC_POLY 16'hA001
`define SC_DIV16 4'hF
`define SC_HALF16 4'h7
`define SC_RST_CTRL 8'h00
`define SC_RST_MODE 8'h0C
`endif

//--- sc_channel.v
/*
 * one serial channel: async and byte-synchronous transmit and receive,
 * three-deep receive buffer, crc and sync fill, interrupt pending flags.
 * assumes bit clocks, data and modem pins come from outside clk_sys_i
 * and are much slower than it; the register port is on clk_sys_i.
 */
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "sc_defines.vh"
module sc_channel #(
    parameter RX_DEPTH = 3
)(
    // clock and reset
    input wire clk_sys_i,
    input wire rst_b_i,
    // register port
    input wire [2:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // serial link
    input wire receive_bit_clock_i,
    input wire transmit_bit_clock_i,
    input wire rxd_i,
    output reg txd_o,
    // modem and sync pins, interrupt output
    input wire cts_b_i,
    input wire carrier_detect_in_b_i,
    input wire sync_b_i,
    output reg sync_b_o,
    output reg sync_oe_o,
    output reg int_o
);
localparam RI = 4'b0001;
localparam RS = 4'b0010;
localparam RD = 4'b0100;
localparam RP = 4'b1000;
localparam TI = 4'b0001;
localparam TD = 4'b0010;
localparam TC = 4'b0100;
localparam TS = 4'b1000;

// ****************
// helpers
// ****************
// right-justify a byte assembled from the top down
function [7:0] align;
    input [7:0] b;
    input [2:0] nb;
    begin
        align = b >> (3'd7 - nb);
    end
endfunction

function [15:0] crc_step;
    input [15:0] c;
    input d;
    begin
        crc_step = (c >> 1) ^ ((c[0] ^ d) ? `SC_CRC_POLY : 16'h0000);
    end
endfunction

// ****************
// pin synchronisers
// ****************
reg [5:0] s1_ff;
reg [5:0] s2_ff;
reg rxc_d_ff;
reg txc_d_ff;
reg cts_d_ff;
wire rxc_s = s2_ff[0];
wire txc_s = s2_ff[1];
wire rxd_s = s2_ff[2];
wire cts_s = s2_ff[3];
wire dcd_s = s2_ff[4];
wire syn_s = s2_ff[5];
// two flops per pin, then a delayed copy for edges
always @(posedge clk_sys_i)
begin
    s1_ff <= {sync_b_i, carrier_detect_in_b_i, cts_b_i, rxd_i, transmit_bit_clock_i, receive_bit_clock_i};
    s2_ff <= s1_ff;
    rxc_d_ff <= rxc_s;
    txc_d_ff <= txc_s;
    cts_d_ff <= cts_s;
end
wire rxc_rise = rxc_s & ~rxc_d_ff;
wire txc_fall = ~txc_s & txc_d_ff;

// ****************
// control registers
// ****************
reg [7:0] ctrl_ff;
reg [7:0] mode_ff;
reg [7:0] sync1_ff;
reg [7:0] sync2_ff;
wire wr_data = reg_wr_i & (reg_addr_i == `SC_A_DATA);
wire rd_data = reg_rd_i & (reg_addr_i == `SC_A_DATA);
wire wr_cmd = reg_wr_i & (reg_addr_i == `SC_A_CMD);
wire hunt_cmd = reg_wr_i & (reg_addr_i == `SC_A_CTRL) & reg_wdata_i[`SC_C_HUNT];
wire [1:0] sy = mode_ff[`SC_M_SYNC];
wire is_async = (sy == `SC_SY_ASYNC);
wire is_int = (sy == `SC_SY_MONO) | (sy == `SC_SY_BI);
wire [2:0] nb = {1'b0, mode_ff[`SC_M_BITS]} + 3'd4;
// sync modes force x1
wire x16 = is_async & mode_ff[`SC_M_X16];
wire [3:0] dv = x16 ? `SC_DIV16 : 4'h0;
wire [3:0] hv = x16 ? `SC_HALF16 : 4'h0;
wire auto_g = ctrl_ff[`SC_C_AUTO];
wire tx_ok = ctrl_ff[`SC_C_TXEN] & ~(auto_g & cts_s);
wire rx_ok = ctrl_ff[`SC_C_RXEN] & ~(auto_g & dcd_s);
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
    begin
        ctrl_ff <= `SC_RST_CTRL;
        mode_ff <= `SC_RST_MODE;
        sync1_ff <= 8'h00;
        sync2_ff <= 8'h00;
    end
    else if (reg_wr_i)
    begin
        case (reg_addr_i)
            `SC_A_CTRL: ctrl_ff <= reg_wdata_i & 8'hDF; // hunt bit is a pulse
            `SC_A_MODE: mode_ff <= reg_wdata_i;
            `SC_A_SYNC1: sync1_ff <= reg_wdata_i;
            `SC_A_SYNC2: sync2_ff <= reg_wdata_i;
            default: ;
        endcase
    end
end

// ****************
// receiver
// ****************
reg [3:0] rx_ph_ff;
reg [3:0] rx_div_ff;
reg [2:0] rx_cnt_ff;
reg [15:0] rx_sr_ff;
reg hunt_ff;
wire [15:0] sr_in = {rxd_s, rx_sr_ff[15:1]};
wire rx_tick = rxc_rise & (rx_div_ff == 4'h0);
wire sy_hit = rx_ok & rxc_rise & ((sy == `SC_SY_MONO) ? (sr_in[15:8] == sync1_ff) :
              (sy == `SC_SY_BI) & (sr_in == {sync2_ff, sync1_ff}));
wire a_push = is_async & rx_ph_ff[3] & rx_tick;
wire s_push = ~is_async & ~hunt_ff & rxc_rise & (rx_cnt_ff == nb);
wire rx_push = rx_ok & (a_push | s_push);
wire [7:0] rx_char = align(a_push ? rx_sr_ff[15:8] : sr_in[15:8], nb);
wire rx_fe = a_push & ~rxd_s;
// bit assembly; disable or hunt command drops sync
always @(posedge clk_sys_i)
begin
    // hunt after reset, on command or disable
    if (!rst_b_i | hunt_cmd | ~rx_ok)
    begin
        rx_ph_ff <= RI;
        rx_div_ff <= 4'h0;
        rx_cnt_ff <= 3'h0;
        rx_sr_ff <= 16'h0000;
        hunt_ff <= 1'b1;
    end
    else if (is_async)
    begin
        hunt_ff <= 1'b1;
        if (rxc_rise)
        begin
            rx_div_ff <= rx_div_ff - 4'h1;
            case (rx_ph_ff)
                RI:
                begin
                    if (!rxd_s)
                    begin
                        rx_ph_ff <= RS;
                        rx_div_ff <= hv;
                    end
                end
                // still low after half a bit in x16, at the next bit clock in x1
                RS:
                begin
                    if (rx_tick)
                    begin
                        rx_ph_ff <= rxd_s ? RI : RD;
                        rx_div_ff <= dv;
                        rx_cnt_ff <= 3'h0;
                    end
                end
                RD:
                begin
                    if (rx_tick)
                    begin
                        rx_sr_ff <= {rxd_s, rx_sr_ff[15:9], 8'h00};
                        rx_div_ff <= dv;
                        rx_cnt_ff <= rx_cnt_ff + 3'h1;
                        if (rx_cnt_ff == nb)
                            rx_ph_ff <= RP;
                    end
                end
                RP:
                begin
                    if (rx_tick)
                        rx_ph_ff <= RI;
                end
                default: rx_ph_ff <= RI;
            endcase
        end
    end
    else if (rxc_rise)
    begin
        rx_sr_ff <= sr_in;
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
        if (hunt_ff)
        begin
            if (sy_hit)
            begin
                hunt_ff <= 1'b0;
                rx_cnt_ff <= 3'h0;
            end
            // this edge carries the first bit
            else if ((sy == `SC_SY_EXT) & ~syn_s)
            begin
                hunt_ff <= 1'b0;
                rx_cnt_ff <= 3'h1;
            end
        end
        else if (rx_cnt_ff == nb)
            rx_cnt_ff <= 3'h0;
    end
end

// sync pin low for the clock of each detection
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
    begin
        sync_b_o <= 1'b1;
        sync_oe_o <= 1'b0;
    end
    else
    begin
        sync_oe_o <= is_int;
        if (sy_hit)
            sync_b_o <= 1'b0;
        else if (rxc_rise | ~is_int)
            sync_b_o <= 1'b1;
    end
end

// ****************
// receive buffer
// ****************
reg [7:0] rx_mem [0:RX_DEPTH-1];
reg [1:0] rx_err [0:RX_DEPTH-1];
reg [1:0] rx_n_ff;
reg armed_ff;
reg pend_rx_ff;
wire rx_full = (rx_n_ff == RX_DEPTH);
wire rx_pop = rd_data & (rx_n_ff != 2'h0);
wire [1:0] n_pop = rx_n_ff - {1'b0, rx_pop};
wire [1:0] slot = (rx_full & ~rx_pop) ? (rx_n_ff - 2'h1) : n_pop;
genvar gi;
// each stage keeps its character and flags together
generate
    for (gi = 0; gi < RX_DEPTH; gi = gi + 1)
    begin : g_rxb
        always @(posedge clk_sys_i)
        begin
            if (!rst_b_i)
            begin
                rx_mem[gi] <= 8'h00;
                rx_err[gi] <= 2'h0;
            end
            else if (rx_push & (slot == gi))
            begin
                rx_mem[gi] <= rx_char;
                rx_err[gi] <= {rx_full & ~rx_pop, rx_fe};
            end
            else if (rx_pop & (gi < RX_DEPTH - 1))
            begin
                rx_mem[gi] <= rx_mem[(gi + 1) % RX_DEPTH];
                rx_err[gi] <= rx_err[(gi + 1) % RX_DEPTH];
            end
            else if (wr_cmd & (reg_wdata_i[2:0] == `SC_CMD_ERR_RST))
                rx_err[gi][1] <= 1'b0;
        end
    end
endgenerate
// count falls to zero as the host reads out
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
        rx_n_ff <= 2'h0;
    else if (rx_push & ~(rx_full & ~rx_pop))
        rx_n_ff <= n_pop + 2'h1; // a read frees a stage for the arriving character
    else
        rx_n_ff <= n_pop;
end
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
    begin
        armed_ff <= 1'b1;
        pend_rx_ff <= 1'b0;
    end
    else
    begin
        if (rx_push & armed_ff)
            armed_ff <= 1'b0;
        else if (wr_cmd & (reg_wdata_i[2:0] == `SC_CMD_REARM))
            armed_ff <= 1'b1;
        // a new event wins over the read that clears
        if (rx_push & (armed_ff | rx_fe | rx_full))
            pend_rx_ff <= 1'b1;
        else if (rd_data)
            pend_rx_ff <= 1'b0;
    end
end
wire [1:0] rim = mode_ff[`SC_M_RXIM];
wire rx_irq = ((rim == `SC_RI_FIRST) & pend_rx_ff) | ((rim == `SC_RI_EVERY) & (rx_n_ff != 2'h0));

// ****************
// transmitter
// ****************
reg [3:0] tx_st_ff;
reg [3:0] tdiv_ff;
reg [4:0] tleft_ff;
reg [15:0] tsr_ff;
reg [7:0] tbuf_ff;
reg tfull_ff;
reg [15:0] crc_ff;
reg crc_inc_ff;
reg sent_ff;
reg pend_tx_ff;
reg pend_es_ff;
wire brk = ctrl_ff[`SC_C_BRK];
wire crc_en = ctrl_ff[`SC_C_CRCEN];
wire t_tick = txc_fall & (tdiv_ff == 4'h0);
wire ld_data = tx_st_ff[0] & ~brk & tx_ok & tfull_ff;
wire ld_fill = tx_st_ff[0] & ~brk & ~ld_data & ~is_async & ctrl_ff[`SC_C_TXEN];
wire ld_crc = ld_fill & crc_en & ~sent_ff;
wire crc_done = tx_st_ff[2] & t_tick & (tleft_ff == 5'h01);
wire cmd_is_txi = wr_cmd & (reg_wdata_i[2:0] == `SC_CMD_RST_TXI);
// empty except while holding a character or sending crc
wire tx_empty = ~tfull_ff & ~tx_st_ff[2];
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
    begin
        tx_st_ff <= TI;
        tdiv_ff <= 4'h0;
        tleft_ff <= 5'h00;
        tsr_ff <= 16'h0000;
        txd_o <= 1'b1;
        crc_inc_ff <= 1'b0;
    end
    // break spaces at once, drops the character
    else if (brk)
    begin
        tx_st_ff <= TI;
        txd_o <= 1'b0;
    end
    // start, data low bit first, stop in async
    else if (ld_data)
    begin
        tx_st_ff <= TD;
        // stop level fills above the programmed length so short words end marking
        tsr_ff <= is_async ? ({7'h7F, tbuf_ff, 1'b0} | (16'hFFFF << ({2'h0, nb} + 5'h02))) : {8'h00, tbuf_ff};
        tleft_ff <= is_async ? {2'h0, nb} + 5'h03 : {2'h0, nb} + 5'h01;
        crc_inc_ff <= crc_en;
    end
    else if (ld_crc)
    begin
        tx_st_ff <= TC;
        tsr_ff <= crc_ff;
        tleft_ff <= 5'h10;
    end
    else if (ld_fill)
    begin
        tx_st_ff <= TS;
        tsr_ff <= {sync2_ff, sync1_ff};
        tleft_ff <= (sy == `SC_SY_BI) ? 5'h10 : 5'h08;
    end
    else if (txc_fall)
    begin
        tdiv_ff <= (tdiv_ff == 4'h0) ? dv : tdiv_ff - 4'h1;
        if (t_tick)
        begin
            // idle or just disabled: mark after the last bit
            txd_o <= tx_st_ff[0] ? 1'b1 : tsr_ff[0];
            tsr_ff <= {1'b0, tsr_ff[15:1]};
            tleft_ff <= tleft_ff - 5'h01;
            if (tleft_ff == 5'h01)
                tx_st_ff <= TI;
        end
    end
    else if (tx_st_ff[0] & ~txc_s & ~tx_ok)
        txd_o <= 1'b1; // disabled while idle: release break or hold mark
end

// crc, buffer and pending flags
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
    begin
        tbuf_ff <= 8'h00;
        tfull_ff <= 1'b0;
        crc_ff <= 16'h0000;
        sent_ff <= 1'b0;
        pend_tx_ff <= 1'b0;
        pend_es_ff <= 1'b0;
    end
    else
    begin
        // five-bit data arrives already masked by the host
        if (wr_data)
        begin
            tbuf_ff <= reg_wdata_i;
            tfull_ff <= 1'b1;
        end
        else if (ld_data)
            tfull_ff <= 1'b0;
        // crc over data only, never over fill
        if (wr_cmd & (reg_wdata_i[2:0] == `SC_CMD_RST_CRC))
            crc_ff <= 16'h0000;
        else if (tx_st_ff[1] & t_tick & crc_inc_ff & ~is_async)
            crc_ff <= crc_step(crc_ff, tsr_ff[0]);
        // flag holds off crc until cleared
        if (ld_fill & ~sent_ff)
            sent_ff <= 1'b1;
        else if (wr_cmd & (reg_wdata_i[2:0] == `SC_CMD_RST_SENT))
            sent_ff <= 1'b0;
        // empty transition raises, write or command clears
        if ((ld_data & ~wr_data) | crc_done)
            pend_tx_ff <= 1'b1;
        else if (wr_data | cmd_is_txi)
            pend_tx_ff <= 1'b0;
        // crc start, first sync, cts change
        if ((ld_fill & ~sent_ff) | (cts_s ^ cts_d_ff))
            pend_es_ff <= 1'b1;
        else if (wr_cmd & (reg_wdata_i[2:0] == `SC_CMD_RST_ES))
            pend_es_ff <= 1'b0;
    end
end

// ****************
// read port and interrupt
// ****************
always @(posedge clk_sys_i)
begin
    if (!rst_b_i)
    begin
        reg_rdata_o <= 8'h00;
        int_o <= 1'b0;
    end
    else
    begin
        int_o <= (pend_tx_ff & ctrl_ff[`SC_C_TXIE]) | (pend_es_ff & ctrl_ff[`SC_C_ESIE]) | rx_irq;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `SC_A_DATA: reg_rdata_o <= rx_mem[0];
                `SC_A_CTRL: reg_rdata_o <= ctrl_ff;
                `SC_A_MODE: reg_rdata_o <= mode_ff;
                `SC_A_SYNC1: reg_rdata_o <= sync1_ff;
                `SC_A_SYNC2: reg_rdata_o <= sync2_ff;
                `SC_A_STAT: reg_rdata_o <= {pend_es_ff, pend_tx_ff, pend_rx_ff, sent_ff,
                                           cts_s, hunt_ff, tx_empty, rx_n_ff != 2'h0};
                `SC_A_ERR: reg_rdata_o <= {6'h00, rx_err[0]};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
end
endmodule

//--- sc_channel_properties.sv
/*
 * port checks for the serial channel, bound to sc_channel from the bench.
 * assumes register writes follow the one-cycle strobe contract.
 */
`timescale 1ns/1ps
`include "sc_defines.vh"
module sc_channel_properties (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_b_i,
    // register writes
    input wire [2:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    // observed outputs
    input wire txd_o,
    input wire sync_b_o,
    input wire sync_oe_o,
    input wire int_o
);
    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [11:0] off_cnt_ff;
    logic irq_en;

    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // shadow of control and mode, taken from the write strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_ff <= `SC_RST_CTRL;
            mode_ff <= `SC_RST_MODE;
        end
        else if (reg_wr_i && reg_addr_i == `SC_A_CTRL)
            ctrl_ff <= reg_wdata_i;
        else if (reg_wr_i && reg_addr_i == `SC_A_MODE)
            mode_ff <= reg_wdata_i;
    end

    // cycles with enable and break both off; saturates so a long idle stays visible
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i || ctrl_ff[0] || ctrl_ff[3])
            off_cnt_ff <= 12'h000;
        else if (off_cnt_ff != 12'hFFF)
            off_cnt_ff <= off_cnt_ff + 12'h001;
    end

    // any interrupt source enabled
    assign irq_en = ctrl_ff[6] | ctrl_ff[7] | (mode_ff[7:6] != 2'h0);

    a_reset_quiet: assert property ($rose(rst_b_i) |-> txd_o && sync_b_o && !sync_oe_o && !int_o)
        else $error("outputs not idle after reset");
    a_break_hold: assert property (ctrl_ff[3] && $past(ctrl_ff[3], 3) |-> !txd_o)
        else $error("line not spacing during break");
    a_mark_off: assert property (off_cnt_ff == 12'hFFF |-> txd_o)
        else $error("line not marking with transmitter off");
    a_bit_steady: assert property ($changed(txd_o) |=> ($stable(txd_o) || ctrl_ff[3]) [*6])
        else $error("transmit bit shorter than a bit clock");
    a_sync_oe_mode: assert property (mode_ff == $past(mode_ff, 2)
        |-> sync_oe_o == (mode_ff[1:0] == 2'h1 || mode_ff[1:0] == 2'h2))
        else $error("sync pin direction does not follow mode");
    a_sync_pulse: assert property ($fell(sync_b_o) |-> ##[1:16] sync_b_o)
        else $error("sync pin low too long");
    a_sync_rx_on: assert property ($fell(sync_b_o) |-> ctrl_ff[1] && sync_oe_o)
        else $error("sync detected with receiver off");
    a_int_enable: assert property ($rose(int_o) |-> irq_en || $past(irq_en))
        else $error("interrupt without enable");
    a_txint_clear: assert property (reg_wr_i && reg_addr_i == `SC_A_CMD && reg_wdata_i[2:0] == `SC_CMD_RST_TXI
        && !ctrl_ff[7] && mode_ff[7:6] == 2'h0 |-> ##[1:3] !int_o)
        else $error("transmit interrupt not cleared");
endmodule

//--- sc_remote.sv
/*
 * remote station on the serial link: bit clock, async and sync sender, async receiver.
 * assumes the channel samples these lines with a much faster system clock.
 */
`timescale 1ns/1ps
module sc_remote (
    // clocks toward the channel
    output logic receive_bit_clock_o,
    output logic transmit_bit_clock_o,
    // data lines
    output logic rxd_o,
    input wire logic txd_i
);
    logic run = 1'b0;
    logic bclk = 1'b1;

    // 200 ns bit clock, still between bursts so no stray edges reach the channel
    initial forever
    begin
        #100;
        if (run)
            bclk = ~bclk;
    end
    assign receive_bit_clock_o = bclk;
    assign transmit_bit_clock_o = bclk;
    initial rxd_o = 1'b1;

    // one level for n periods, changed just after a falling edge
    task automatic hold(input logic b, input int n);
        run = 1'b1;
        @(negedge bclk);
        rxd_o = b;
        repeat (n - 1) @(negedge bclk);
    endtask

    // the last bit gets its rising edge, then the clock stops and the line marks
    task automatic stop();
        @(negedge bclk);
        run = 1'b0;
        rxd_o = 1'b1;
    endtask

    // start bit held a full bit, twice what the channel needs
    task automatic send_async(input logic [7:0] d);
        hold(1'b0, 16);
        for (int i = 0; i < 8; i++) hold(d[i], 16);
        hold(1'b1, 16);
        stop();
    endtask

    // low for well under half a bit, then marking
    task automatic glitch();
        hold(1'b0, 3);
        hold(1'b1, 16);
        stop();
    endtask

    // one bit per x1 period, moved on the falling edge
    task automatic send_sync(input logic [7:0] d);
        for (int i = 0; i < 8; i++) hold(d[i], 1);
    endtask

    // transmit data taken mid-bit, far from the edges where it moves
    task automatic get_async(input int nb, output logic [15:0] v);
        v = 16'h0000;
        run = 1'b1;
        @(negedge txd_i);
        repeat (8) @(negedge bclk);
        for (int i = 0; i <= nb; i++)
        begin
            repeat (16) @(negedge bclk);
            v[i] = txd_i;
        end
        run = 1'b0;
    endtask
endmodule

//--- sc_channel_test.sv
/*
 * self-checking bench for the serial channel over its register port and link.
 * assumes sc_channel, sc_remote and the checker are compiled before it.
 */
`timescale 1ns/1ps
`include "sc_defines.vh"
module sc_channel_test;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic cts_b_i = 1'b1;
    logic carrier_detect_in_b_i = 1'b1;
    wire [7:0] reg_rdata_o;
    wire rbc;
    wire tbc;
    wire rxd_i;
    wire txd_o;
    wire sync_b_o;
    wire sync_oe_o;
    wire int_o;
    wire sync_b_i;
    logic ext_sync_b = 1'b1;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int tx_falls = 0;
    int sync_hits = 0;
    logic [15:0] v;
    logic [7:0] rx_bytes [3] = '{8'h3C, 8'hC3, 8'h5A};

    // shared sync pin: the channel drives it in internal sync modes, the remote side otherwise
    assign sync_b_i = sync_oe_o ? sync_b_o : ext_sync_b;

    // 40 MHz system clock
    initial forever #12.5 clk_sys_i = ~clk_sys_i;

    sc_channel sc_channel_i (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .receive_bit_clock_i(rbc),
        .transmit_bit_clock_i(tbc),
        .rxd_i(rxd_i),
        .txd_o(txd_o),
        .cts_b_i(cts_b_i),
        .carrier_detect_in_b_i(carrier_detect_in_b_i),
        .sync_b_i(sync_b_i),
        .sync_b_o(sync_b_o),
        .sync_oe_o(sync_oe_o),
        .int_o(int_o)
    );

    sc_remote sc_remote_i (
        .receive_bit_clock_o(rbc),
        .transmit_bit_clock_o(tbc),
        .rxd_o(rxd_i),
        .txd_i(txd_o)
    );

    // line events counted outside reset
    always @(negedge txd_o) if (rst_b_i === 1'b1) tx_falls++;
    always @(negedge sync_b_o) if (rst_b_i === 1'b1) sync_hits++;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stands from the cycle after the read edge and holds until the next read
    task automatic expect_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        check({8'h00, reg_rdata_o & m}, {8'h00, e});
    endtask

    // bounded wait for the request line
    task automatic wait_int();
        for (int k = 0; k < 600 && int_o !== 1'b1; k++) @(posedge clk_sys_i);
        #1;
        chk1(int_o, 1'b1);
    endtask

    // watchdog well above the expected run length
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        expect_reg(`SC_A_CTRL, 8'hFF, 8'h00);
        expect_reg(`SC_A_MODE, 8'hFF, 8'h0C);
        expect_reg(`SC_A_STAT, 8'h03, 8'h02);
        // transmitter held by enable, then by clear-to-send
        wr(`SC_A_MODE, 8'h1C);
        wr(`SC_A_DATA, 8'h4B);
        sc_remote_i.hold(1'b1, 40);
        sc_remote_i.stop();
        expect_reg(`SC_A_STAT, 8'h02, 8'h00);
        wr(`SC_A_CTRL, 8'h45);
        sc_remote_i.hold(1'b1, 40);
        sc_remote_i.stop();
        check(16'(tx_falls), 16'h0000);
        fork
            sc_remote_i.get_async(8, v);
            begin
                @(posedge clk_sys_i);
                cts_b_i <= 1'b0;
                wait_int();
                expect_reg(`SC_A_STAT, 8'h02, 8'h02);
                wr(`SC_A_CMD, 8'h05);
            end
        join
        check(v, 16'h014B);
        chk1(int_o, 1'b0);
        // five-bit characters
        wr(`SC_A_MODE, 8'h10);
        fork
            sc_remote_i.get_async(5, v);
            wr(`SC_A_DATA, 8'h15);
        join
        check(v, 16'h0035);
        chk1(int_o, 1'b1);
        wr(`SC_A_CMD, 8'h05);
        settle(3);
        chk1(int_o, 1'b0);
        // break
        wr(`SC_A_CTRL, 8'h09);
        settle(24);
        chk1(txd_o, 1'b0);
        // withdrawn with the transmitter off: the line marks without waiting for a bit clock
        wr(`SC_A_CTRL, 8'h00);
        settle(4);
        chk1(txd_o, 1'b1);
        // receiver gating: carrier high under auto, then receiver off
        wr(`SC_A_MODE, 8'h5C);
        for (int i = 0; i < 2; i++)
        begin
            wr(`SC_A_CTRL, i ? 8'h00 : 8'h06);
            sc_remote_i.send_async(8'h11);
            settle(20);
            expect_reg(`SC_A_STAT, 8'h01, 8'h00);
        end
        @(posedge clk_sys_i);
        carrier_detect_in_b_i <= 1'b0;
        wr(`SC_A_CTRL, 8'h06);
        sc_remote_i.glitch();
        settle(20);
        expect_reg(`SC_A_STAT, 8'h01, 8'h00);
        sc_remote_i.send_async(8'hA5);
        wait_int();
        expect_reg(`SC_A_DATA, 8'hFF, 8'hA5);
        foreach (rx_bytes[i]) sc_remote_i.send_async(rx_bytes[i]);
        settle(20);
        chk1(int_o, 1'b0);
        expect_reg(`SC_A_STAT, 8'h01, 8'h01);
        foreach (rx_bytes[i]) expect_reg(`SC_A_DATA, 8'hFF, rx_bytes[i]);
        expect_reg(`SC_A_STAT, 8'h01, 8'h00);
        wr(`SC_A_CMD, 8'h04);
        sc_remote_i.send_async(8'h81);
        wait_int();
        expect_reg(`SC_A_DATA, 8'hFF, 8'h81);
        // single-character sync hunt and assembly
        wr(`SC_A_CTRL, 8'h00);
        wr(`SC_A_MODE, 8'h0D);
        wr(`SC_A_SYNC1, 8'h96);
        wr(`SC_A_CTRL, 8'h02);
        expect_reg(`SC_A_STAT, 8'h04, 8'h04);
        sc_remote_i.send_sync(8'h96);
        sc_remote_i.send_sync(8'h2D);
        sc_remote_i.stop();
        settle(20);
        check(16'(sync_hits), 16'h0001);
        expect_reg(`SC_A_STAT, 8'h04, 8'h00);
        expect_reg(`SC_A_DATA, 8'hFF, 8'h2D);
        wr(`SC_A_CTRL, 8'h22);
        expect_reg(`SC_A_STAT, 8'h04, 8'h04);
        // external sync: pin falls after the first data bit is set up
        wr(`SC_A_CTRL, 8'h00);
        wr(`SC_A_MODE, 8'h0F);
        wr(`SC_A_CTRL, 8'h02);
        fork
            sc_remote_i.send_sync(8'hC6);
            begin
                @(negedge rbc);
                @(posedge clk_sys_i);
                ext_sync_b <= 1'b0;
            end
        join
        sc_remote_i.stop();
        @(posedge clk_sys_i);
        ext_sync_b <= 1'b1;
        settle(20);
        expect_reg(`SC_A_STAT, 8'h04, 8'h00);
        expect_reg(`SC_A_DATA, 8'hFF, 8'hC6);
        // transmitter on in a sync mode loads the first fill at once
        wr(`SC_A_CMD, 8'h02);
        expect_reg(`SC_A_STAT, 8'h90, 8'h00);
        wr(`SC_A_CTRL, 8'h03);
        expect_reg(`SC_A_STAT, 8'h90, 8'h90);
        tally_and_finish();
    end
endmodule

bind sc_channel sc_channel_properties sc_channel_properties_i (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .txd_o(txd_o),
    .sync_b_o(sync_b_o),
    .sync_oe_o(sync_oe_o),
    .int_o(int_o)
);
